// >>> core/adsc_pkg.sv
// Purpose: Shared constants, states and decode helpers for the converter sequencer
// Assumes: One 200 MHz clock; registers on AHB-Lite word offsets
// Notes:   All offsets and field positions, plus the multi-bit field reset values and timing counts, live here
package adsc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PORTREF = 8'h04;
   localparam logic [7:0] OFS_FMTTIM  = 8'h08;
   localparam logic [7:0] OFS_RESH    = 8'h0c;
   localparam logic [7:0] OFS_RESL    = 8'h10;
   localparam logic [7:0] OFS_IRQ     = 8'h14;

   // Field positions
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_GO_BIT     = 1;
   localparam int CTRL_CHS_LSB    = 2;
   localparam int PREF_NEG_BIT    = 5;
   localparam int PREF_POS_BIT    = 4;
   localparam int PREF_PCFG_LSB   = 0;
   localparam int FMT_JUST_BIT    = 7;
   localparam int FMT_ACQ_LSB     = 3;
   localparam int FMT_CLK_LSB     = 0;
   localparam int IRQ_FLAG_BIT    = 0;
   localparam int IRQ_EN_BIT      = 1;

   // Reset values
   localparam logic [3:0] CHS_RST     = 4'h0;
   localparam logic [3:0] PCFG_RST    = 4'h0;
   localparam logic [2:0] ACQ_RST     = 3'h0;
   localparam logic [2:0] CLK_RST     = 3'h0;

   // Timing in bit periods (TCY_TOSC in core clocks), plus port map and SAR constants
   localparam logic [4:0] CONV_TICKS  = 5'h0b;
   localparam logic [4:0] WAIT_TICKS  = 5'h03;
   localparam logic [2:0] TCY_TOSC    = 3'h4;
   localparam logic [3:0] PCFG_ALL_AN = 4'h3;
   localparam logic [4:0] PCFG_DIG_TOP = 5'h0f;
   localparam logic [9:0] SAR_FIRST   = 10'h200;
   localparam int         NUM_CH      = 12;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_DELAY = 5'h02,
      ST_ACQ   = 5'h04,
      ST_CONV  = 5'h08,
      ST_WAIT  = 5'h10
   } adsc_state_e;

   function automatic logic [4:0] adsc_acq_ticks(input logic [2:0] code);
      case (code)
         3'h0: adsc_acq_ticks = 5'h00;
         3'h1: adsc_acq_ticks = 5'h02;
         3'h2: adsc_acq_ticks = 5'h04;
         3'h3: adsc_acq_ticks = 5'h06;
         3'h4: adsc_acq_ticks = 5'h08;
         3'h5: adsc_acq_ticks = 5'h0c;
         3'h6: adsc_acq_ticks = 5'h10;
         default: adsc_acq_ticks = 5'h14;
      endcase
   endfunction

   // Divider terminal count, divisor minus one
   function automatic logic [5:0] adsc_div_last(input logic [2:0] code);
      case (code)
         3'h0: adsc_div_last = 6'h01;
         3'h1: adsc_div_last = 6'h07;
         3'h2: adsc_div_last = 6'h1f;
         3'h4: adsc_div_last = 6'h03;
         3'h5: adsc_div_last = 6'h0f;
         3'h6: adsc_div_last = 6'h3f;
         default: adsc_div_last = 6'h01;
      endcase
   endfunction

endpackage

// >>> core/adsc_top.sv
// Purpose: Sequencer and register file of a 10-bit successive-approximation converter
// Assumes: AHB-Lite slave, zero wait states; all inputs but rc_osc_in synchronous to core_clk
// Notes:   Result registers carry no reset so power-up leaves them untouched
//
// Overview of operation
// - Negative reference bit set selects external low reference, else analog ground.
// - Positive reference bit set selects external high reference, else analog supply.
// - Port codes 0-3 all analog; each higher code turns one more channel digital.
// - Justify bit set right-aligns the result, cleared left-aligns it.
// - Acquisition code picks 0,2,4,6,8,12,16 or 20 bit periods.
// - Clock code divides system clock by 2,8,32,4,16,64; x11 picks RC.
// - RC clock source adds one instruction cycle before the bit clock starts.
// - Reset restores all but the result registers, switches the converter off and aborts conversions.
// - Completion loads result pair, clears go and sets the done flag.
// - Power-on reset leaves the result pair unmodified.
// - At least 3 bit periods pass after a conversion before acquisition.
// - Zero acquisition code: go stops sampling and converts at once.
// - Nonzero acquisition code samples for that many periods, then converts.
// - After each conversion sampling of the selected channel resumes by itself.
// - Go stays set across acquisition and conversion, with no phase indication.
// - Unimplemented configuration bits read as zero.
// - Conversion runs during sleep only when the RC clock is selected.
// - Holding capacitor leaves the input when conversion begins.
// - Result is found by successive approximation, one bit per period.
// - Go reads one while converting; enable bit switches the converter.
// - Channel field selects channels 0-11; codes 12-15 are unimplemented.
// - A conversion takes 11 bit periods.
// - Clearing go mid-conversion aborts and keeps the previous result.
`timescale 1ns/1ps
`default_nettype none

module adsc_top
   import adsc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rc_osc_in,
   input  wire logic        sleep_in,
   input  wire logic        cmp_in,
   output logic [9:0]       sar_code,
   output logic             sample_en,
   output logic [3:0]       chan_sel,
   output logic [11:0]      analog_en,
   output logic             vref_neg_ext,
   output logic             vref_pos_ext,
   output logic             converter_on,
   output logic             conv_done_irq
);

   // Register state
   logic              conv_en_r;
   logic              go_r;
   logic [3:0]        chs_r;
   logic              neg_ref_r;
   logic              pos_ref_r;
   logic [3:0]        pcfg_r;
   logic              justify_r;
   logic [2:0]        acq_sel_r;
   logic [2:0]        clk_sel_r;
   logic [7:0]        res_hi_r;
   logic [7:0]        res_lo_r;
   logic              done_flag_r;
   logic              irq_en_r;

   // Bus state
   logic              wr_pend_r;
   logic [7:0]        wr_addr_r;
   logic              hreadyout_r;
   logic [31:0]       hrdata_r;
   logic              hresp_r;
   logic              addr_ok;
   logic [7:0]        rd_byte;
   logic              wr_ctrl;
   logic              wr_pref;
   logic              wr_fmt;
   logic              wr_resh;
   logic              wr_resl;
   logic              wr_irq;

   // Sequencer state
   adsc_state_e       st_r;
   adsc_state_e       st_nxt;
   logic [4:0]        cnt_r;
   logic [2:0]        dly_r;
   logic [5:0]        div_cnt_r;
   logic              rc_s1_r;
   logic              rc_s2_r;
   logic              rc_s3_r;
   logic              rc_sel;
   logic              tick;
   logic              conv_done;
   logic [9:0]        sar_r;
   logic [3:0]        bit_pos;
   logic [15:0]       res_pair;

   // Output flops
   logic              sample_en_r;
   logic [3:0]        chan_sel_r;
   logic [11:0]       analog_en_r;
   logic [11:0]       analog_nxt;
   logic              vref_neg_r;
   logic              vref_pos_r;
   logic              conv_on_r;
   logic              irq_r;

   // ---------------- AHB-Lite slave ----------------
   assign addr_ok = hsel && htrans[1] && hready;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else begin
         wr_pend_r   <= addr_ok && hwrite;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
         if (addr_ok) begin
            wr_addr_r <= haddr[7:0];
         end
      end
   end

   // Unmapped addresses read zero and drop writes
   always_comb begin
      wr_ctrl = 1'b0;
      wr_pref = 1'b0;
      wr_fmt  = 1'b0;
      wr_resh = 1'b0;
      wr_resl = 1'b0;
      wr_irq  = 1'b0;
      if (wr_pend_r && wr_addr_r == OFS_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (wr_pend_r && wr_addr_r == OFS_PORTREF) begin
         wr_pref = 1'b1;
      end else if (wr_pend_r && wr_addr_r == OFS_FMTTIM) begin
         wr_fmt = 1'b1;
      end else if (wr_pend_r && wr_addr_r == OFS_RESH) begin
         wr_resh = 1'b1;
      end else if (wr_pend_r && wr_addr_r == OFS_RESL) begin
         wr_resl = 1'b1;
      end else if (wr_pend_r && wr_addr_r == OFS_IRQ) begin
         wr_irq = 1'b1;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (haddr[7:0] == OFS_CTRL) begin
         rd_byte = {2'b00, chs_r, go_r, conv_en_r};
      end else if (haddr[7:0] == OFS_PORTREF) begin
         rd_byte = {2'b00, neg_ref_r, pos_ref_r, pcfg_r};
      end else if (haddr[7:0] == OFS_FMTTIM) begin
         rd_byte = {justify_r, 1'b0, acq_sel_r, clk_sel_r};
      end else if (haddr[7:0] == OFS_RESH) begin
         rd_byte = res_hi_r;
      end else if (haddr[7:0] == OFS_RESL) begin
         rd_byte = res_lo_r;
      end else if (haddr[7:0] == OFS_IRQ) begin
         rd_byte = {6'h00, irq_en_r, done_flag_r};
      end
   end

   // Read data is latched at the address phase, so it stands the whole data phase
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hrdata_r <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata_r <= {24'h00_0000, rd_byte};
      end else begin
         hrdata_r <= 32'h0000_0000;
      end
   end

   // ---------------- Configuration registers ----------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         conv_en_r <= 1'b0;
         chs_r     <= CHS_RST;
         neg_ref_r <= 1'b0;
         pos_ref_r <= 1'b0;
         pcfg_r    <= PCFG_RST;
         justify_r <= 1'b0;
         acq_sel_r <= ACQ_RST;
         clk_sel_r <= CLK_RST;
         irq_en_r  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            conv_en_r <= hwdata[CTRL_EN_BIT];
            chs_r     <= hwdata[CTRL_CHS_LSB +: 4];
         end
         if (wr_pref) begin
            neg_ref_r <= hwdata[PREF_NEG_BIT];
            pos_ref_r <= hwdata[PREF_POS_BIT];
            pcfg_r    <= hwdata[PREF_PCFG_LSB +: 4];
         end
         if (wr_fmt) begin
            justify_r <= hwdata[FMT_JUST_BIT];
            acq_sel_r <= hwdata[FMT_ACQ_LSB +: 3];
            clk_sel_r <= hwdata[FMT_CLK_LSB +: 3];
         end
         if (wr_irq) begin
            irq_en_r <= hwdata[IRQ_EN_BIT];
         end
      end
   end

   // Go only arms when the converter was already on; writing zero aborts
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         go_r <= 1'b0;
      end else if (!conv_en_r) begin
         go_r <= 1'b0;
      end else if (conv_done) begin
         // Completion clears go even if software rewrites control that cycle
         go_r <= 1'b0;
      end else if (wr_ctrl) begin
         go_r <= hwdata[CTRL_GO_BIT];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         done_flag_r <= 1'b0;
      end else if (conv_done) begin
         done_flag_r <= 1'b1;
      end else if (wr_irq) begin
         done_flag_r <= hwdata[IRQ_FLAG_BIT];
      end
   end

   // ---------------- Bit period generation ----------------
   assign rc_sel = (clk_sel_r[1:0] == 2'b11);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rc_s1_r <= 1'b0;
         rc_s2_r <= 1'b0;
         rc_s3_r <= 1'b0;
      end else begin
         rc_s1_r <= rc_osc_in;
         rc_s2_r <= rc_s1_r;
         rc_s3_r <= rc_s2_r;
      end
   end

   // Divider restarts while idle so the first period is a full one
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_cnt_r <= 6'h00;
      end else if (rc_sel || st_r == ST_IDLE) begin
         div_cnt_r <= 6'h00;
      end else if (sleep_in) begin
         div_cnt_r <= div_cnt_r;
      end else if (div_cnt_r >= adsc_div_last(clk_sel_r)) begin
         div_cnt_r <= 6'h00;
      end else begin
         div_cnt_r <= div_cnt_r + 6'h01;
      end
   end

   // System clock stops in sleep; only the RC source keeps ticking
   always_comb begin
      if (rc_sel) begin
         tick = rc_s2_r && !rc_s3_r && (st_r != ST_DELAY);
      end else begin
         tick = !sleep_in && (st_r != ST_IDLE)
                && (div_cnt_r == adsc_div_last(clk_sel_r));
      end
   end

   // ---------------- Sequencer ----------------
   assign conv_done = (st_r == ST_CONV) && go_r && tick
                      && (cnt_r == CONV_TICKS - 5'h01);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (go_r) begin
               if (rc_sel) begin
                  st_nxt = ST_DELAY;
               end else if (acq_sel_r == 3'h0) begin
                  st_nxt = ST_CONV;
               end else begin
                  st_nxt = ST_ACQ;
               end
            end
         end
         ST_DELAY: begin
            if (!go_r) begin
               st_nxt = ST_WAIT;
            end else if (dly_r == TCY_TOSC - 3'h1) begin
               st_nxt = (acq_sel_r == 3'h0) ? ST_CONV : ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (!go_r) begin
               st_nxt = ST_WAIT;
            end else if (tick && cnt_r == adsc_acq_ticks(acq_sel_r) - 5'h01) begin
               st_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (!go_r) begin
               st_nxt = ST_WAIT;
            end else if (conv_done) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (tick && cnt_r == WAIT_TICKS - 5'h01) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      if (!conv_en_r) begin
         st_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
      end else if (st_nxt != st_r) begin
         cnt_r <= 5'h00;
      end else if (tick) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dly_r <= 3'h0;
      end else if (st_r == ST_DELAY) begin
         dly_r <= dly_r + 3'h1;
      end else begin
         dly_r <= 3'h0;
      end
   end

   // Tick k resolves bit 9-k; the eleventh period closes the conversion
   assign bit_pos = 4'h9 - cnt_r[3:0];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sar_r <= 10'h000;
      end else if (st_nxt == ST_CONV && st_r != ST_CONV) begin
         sar_r <= SAR_FIRST;
      end else if (st_r == ST_CONV && tick && cnt_r < CONV_TICKS - 5'h01) begin
         for (int i = 0; i < 10; i++) begin
            if (4'(i) == bit_pos) begin
               sar_r[i] <= cmp_in;
            end else if (4'(i + 1) == bit_pos) begin
               sar_r[i] <= 1'b1;
            end
         end
      end
   end

   assign res_pair = justify_r ? {6'h00, sar_r} : {sar_r, 6'h00};

   // No reset here: power-up and reset leave the last result in place
   always_ff @(posedge core_clk) begin
      if (conv_done) begin
         res_hi_r <= res_pair[15:8];
         res_lo_r <= res_pair[7:0];
      end else begin
         if (wr_resh) begin
            res_hi_r <= hwdata[7:0];
         end
         if (wr_resl) begin
            res_lo_r <= hwdata[7:0];
         end
      end
   end

   // ---------------- Analog side outputs ----------------
   for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_port
      assign analog_nxt[gi] = (pcfg_r <= PCFG_ALL_AN)
                              || (5'(gi) < PCFG_DIG_TOP - {1'b0, pcfg_r});
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sample_en_r <= 1'b0;
         chan_sel_r  <= CHS_RST;
         analog_en_r <= 12'hfff;
         vref_neg_r  <= 1'b0;
         vref_pos_r  <= 1'b0;
         conv_on_r   <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         sample_en_r <= conv_en_r && (st_nxt == ST_IDLE || st_nxt == ST_DELAY
                        || st_nxt == ST_ACQ);
         chan_sel_r  <= chs_r;
         analog_en_r <= analog_nxt;
         vref_neg_r  <= neg_ref_r;
         vref_pos_r  <= pos_ref_r;
         conv_on_r   <= conv_en_r;
         irq_r       <= done_flag_r && irq_en_r;
      end
   end

   assign hreadyout     = hreadyout_r;
   assign hrdata        = hrdata_r;
   assign hresp         = hresp_r;
   assign sar_code      = sar_r;
   assign sample_en     = sample_en_r;
   assign chan_sel      = chan_sel_r;
   assign analog_en     = analog_en_r;
   assign vref_neg_ext  = vref_neg_r;
   assign vref_pos_ext  = vref_pos_r;
   assign converter_on  = conv_on_r;
   assign conv_done_irq = irq_r;

   // ---------------- Assertions ----------------
   logic [4:0] gap_ticks_r;
   logic [4:0] conv_ticks_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gap_ticks_r  <= 5'h00;
         conv_ticks_r <= 5'h00;
      end else begin
         gap_ticks_r  <= (st_r == ST_WAIT) ? gap_ticks_r + 5'(tick) : 5'h00;
         conv_ticks_r <= (st_r == ST_CONV) ? conv_ticks_r + 5'(tick) : 5'h00;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_done_loads: assert property (conv_done |=> done_flag_r && !go_r
      && {res_hi_r, res_lo_r} == $past(res_pair))
      else $error("completion did not load result and flags");
   a_conv_length: assert property (conv_done |-> conv_ticks_r == 5'h0a)
      else $error("conversion not eleven bit periods");
   a_gap_wait: assert property ((st_r == ST_IDLE && $past(st_r) == ST_WAIT
      && $past(conv_en_r)) |-> gap_ticks_r >= WAIT_TICKS)
      else $error("acquisition restarted too soon");
   a_zero_acq: assert property ((st_r == ST_IDLE && go_r && conv_en_r
      && acq_sel_r == 3'h0 && !rc_sel) |=> st_r == ST_CONV && !sample_en_r)
      else $error("zero acquisition did not convert at once");
   a_hold_disc: assert property (st_r == ST_CONV |-> !sample_en_r)
      else $error("holding capacitor connected during conversion");
   a_acq_sample: assert property (st_r == ST_ACQ |-> sample_en_r
      && (go_r || $past(wr_ctrl)))
      else $error("acquisition phase not sampling");
   a_rc_delay: assert property ((st_r == ST_IDLE && st_nxt == ST_DELAY)
      |=> (st_r == ST_DELAY && go_r) [*4])
      else $error("rc start delay wrong");
   a_abort_keep: assert property ((st_r == ST_CONV && !go_r && !wr_resh
      && !wr_resl) |=> $stable({res_hi_r, res_lo_r}) && st_r != ST_CONV)
      else $error("abort disturbed result");
   a_resume_samp: assert property ((st_r == ST_WAIT && st_nxt == ST_IDLE
      && conv_en_r) |=> sample_en_r ##1 sample_en_r || go_r)
      else $error("sampling did not resume");
   a_port_map: assert property ((pcfg_r == 4'hf) |=> analog_en_r == 12'h000)
      else $error("port map wrong for all digital");
   a_sleep_hold: assert property ((sleep_in && !rc_sel) |-> !tick)
      else $error("system clock ticked in sleep");
   a_reserved_zero: assert property ((addr_ok && !hwrite
      && haddr[7:0] == OFS_PORTREF) |=> hrdata_r[7:6] == 2'b00)
      else $error("reserved bits read nonzero");
   a_irq_gate: assert property (conv_done_irq |-> $past(done_flag_r && irq_en_r))
      else $error("interrupt without enabled flag");
   a_right_just: assert property ((conv_done && justify_r) |=> res_hi_r[7:2] == 6'h00)
      else $error("right justified result misplaced");

   c_zero_acq: cover property (st_r == ST_IDLE ##1 st_r == ST_CONV ##[1:400] conv_done);
   c_prog_acq: cover property (st_r == ST_ACQ ##[1:900] conv_done);
   c_rc_conv: cover property (rc_sel && conv_done);
   c_abort: cover property (st_r == ST_CONV && !go_r);

endmodule

`default_nettype wire

// >>> testbench/adsc_ain_model.sv
// Purpose: Analog input seen through the sample-and-hold
// Assumes: Ideal comparator
// Notes:   Value is frozen while the capacitor is off the pin
`timescale 1ns/1ps
`default_nettype none
module adsc_ain_model (
   input  wire logic       core_clk,
   input  wire logic       sample_en,
   input  wire logic [9:0] sar_code,
   input  wire logic [9:0] ain,
   output logic            cmp_in
);
   logic [9:0] held_r;
   always @(posedge core_clk) if (sample_en) held_r <= ain;
   assign cmp_in = (held_r >= sar_code);
endmodule
`default_nettype wire

// >>> testbench/adsc_top_bench.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Single AHB-Lite slave, zero wait states
// Notes:   Timing checks allow a few cycles of pipeline slack
`timescale 1ns/1ps
`default_nettype none
module adsc_top_bench;
   import adsc_pkg::*;
   logic        core_clk = 0, rst_n = 0, hwrite = 0, rc_osc_in = 0, sleep_in = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic        hreadyout, hresp, cmp_in, sample_en, converter_on, conv_done_irq, vn, vp;
   logic [9:0]  sar_code, v, ain = 0;
   logic [3:0]  chan_sel;
   logic [11:0] analog_en;
   int          err_count = 0, num_checks = 0, cyc = 0, low = 0, seed = 90, d;
   int          dv[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   adsc_top u_adsc_top (.core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rc_osc_in(rc_osc_in),
      .sleep_in(sleep_in), .cmp_in(cmp_in), .sar_code(sar_code), .sample_en(sample_en),
      .chan_sel(chan_sel), .analog_en(analog_en), .vref_neg_ext(vn), .vref_pos_ext(vp),
      .converter_on(converter_on), .conv_done_irq(conv_done_irq));
   adsc_ain_model u_adsc_ain_model (.core_clk(core_clk), .sample_en(sample_en),
      .sar_code(sar_code), .ain(ain), .cmp_in(cmp_in));
   initial forever #2.5 core_clk = ~core_clk;
   // Free-running RC source, never aligned with the core clock
   initial forever #7 rc_osc_in = ~rc_osc_in;
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task stop_test;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (sample_en !== 1'b1) low++;
      if (cyc > 60000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk({analog_en, converter_on, vn, vp, hresp}, 32'hfff0);
      for (int i = 0; i < 7; i++) begin
         if (i != 3 && i != 4) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
         end
      end
      for (int i = 0; i < 64; i++) begin
         bus(1'b1, OFS_PORTREF, 32'hc0 | i);
         bus(1'b0, OFS_PORTREF, 32'h0);
         chk(rd, i);
         chk({vn, vp, (i % 16 < 4) ? 12'hfff : 12'hfff >> (i % 16 - 3)},
             {i[5], i[4], analog_en});
      end
      bus(1'b1, OFS_FMTTIM, 32'hff);
      bus(1'b0, OFS_FMTTIM, 32'h0);
      chk(rd, 32'hbf);
      bus(1'b1, OFS_CTRL, 32'h1);
      bus(1'b1, OFS_IRQ, 32'h2);
      // Long idle gives the held input time to settle before go
      repeat (800) @(posedge core_clk);
      for (int j = 0; j < 7; j++) begin
         v = 10'($random(seed));
         ain <= v;
         sleep_in <= (j == 6);
         bus(1'b1, OFS_FMTTIM, {24'h0, j[0], 1'b0, j[2:0], (j < 3) ? j[2:0] : 3'(j + 1)});
         low = 0;
         bus(1'b1, OFS_CTRL, {26'h0, j[3:0], 2'h3});
         do bus(1'b0, OFS_CTRL, 32'h0); while (rd[CTRL_GO_BIT] === 1'b1);
         chk(rd, {26'h0, j[3:0], 2'h1});
         bus(1'b0, OFS_RESH, 32'h0);
         chk(rd, j[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
         bus(1'b0, OFS_RESL, 32'h0);
         chk(rd, j[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
         chk(sar_code, v);
         bus(1'b0, OFS_IRQ, 32'h0);
         chk({rd[1:0], conv_done_irq, chan_sel}, {3'h7, j[3:0]});
         bus(1'b1, OFS_IRQ, 32'h2);
         repeat (800) @(posedge core_clk);
         d = dv[(j < 3) ? j : j + 1];
         // Low time spans conversion plus the post-conversion wait
         if (j < 6) chk(low >= 14 * d && low <= 14 * d + 4, 1);
         chk(sample_en, 1'b1);
      end
      sleep_in <= 1'b0;
      ain <= ~v;
      bus(1'b1, OFS_FMTTIM, 32'h6);
      bus(1'b1, OFS_CTRL, 32'h3);
      repeat (40) @(posedge core_clk);
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (800) @(posedge core_clk);
      bus(1'b0, OFS_RESL, 32'h0);
      chk(rd, {24'h0, v[1:0], 6'h0});
      bus(1'b0, OFS_IRQ, 32'h0);
      chk(rd, 32'h2);
      bus(1'b1, OFS_CTRL, 32'h3);
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk({converter_on, sample_en}, 2'h0);
      bus(1'b0, OFS_RESL, 32'h0);
      chk(rd, {24'h0, v[1:0], 6'h0});
      stop_test();
   end
endmodule
`default_nettype wire
